// [hmf_pkg.sv]
// Package for the host message framing front end
package hmf_pkg;
    // ------------------------------------------------------------
    // Character codes
    // ------------------------------------------------------------
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam logic [7:0] CH_ENQ = 8'h05;
    localparam logic [7:0] CH_XON = 8'h11;
    localparam logic [7:0] CH_XOFF = 8'h13;
    localparam logic [7:0] CH_SP = 8'h20;
    localparam logic [7:0] CH_TAB = 8'h09;
    // ------------------------------------------------------------
    // Limits and reset values
    // ------------------------------------------------------------
    localparam int MAX_MSG_LEN = 4096;
    localparam int MSG_CNT_W = 13;
    localparam int CMD_LEN_DEF = 32;
    localparam int REC_LEN_DEF = 8;
    localparam logic RST_XOFF = 1'b0;
    // ------------------------------------------------------------
    // Parse result kinds
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        HMF_PK_DEC = 2'h0,
        HMF_PK_HEX = 2'h1,
        HMF_PK_STR = 2'h2
    } hmf_kind_t;
    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } hmf_byte_t;
    typedef struct packed {
        logic valid;
        logic is_hex;
        logic hex_ok;
        logic [31:0] hex_val;
        logic dec_ok;
        logic dec_sci;
        logic [31:0] dec_mant;
        logic [7:0] dec_exp;
        logic str_ok;
        logic [7:0] len;
    } hmf_param_t;
endpackage

// [hmf_front_end.sv]
// Host message framing front end: framing, flow control, service requests, streaming, parameter parsing
// Function
// - Command held incomplete and unused until CR LF pair arrives.
// - Every outgoing message ends CR LF, except USB binary stream records and the lone serial ENQ.
// - No outgoing message exceeds 4096 bytes.
// - Commands and replies are ASCII only; binary bytes are sent only in USB stream records.
// - Serial transmit obeys XON/XOFF when flow control is enabled.
// - Serial sends ENQ when data or error queue becomes non-empty.
// - No ENQ inserted while a query reply is being sent.
// - USB sends attention when data or error queue becomes non-empty.
// - No USB attention sent along with a query reply.
// - With USB and streaming enabled, one binary record per sample arriving while idle; others flagged as dropped.
// - Decimal parameters accept integer, float and E or e exponent.
// - Hex parameters parsed case-insensitively, leading zeros optional.
// - Optional 0x or 0X prefix; then only hex digits accepted.
// - String parameters carry no surrounding quotation marks.
// - Enumerated values match by long-form and short-form keyword rules.
`timescale 1ns/1ps
`default_nettype none
module hmf_front_end #(
    parameter int CMD_LEN = hmf_pkg::CMD_LEN_DEF,
    parameter int REC_LEN = hmf_pkg::REC_LEN_DEF
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Configuration
    input wire logic use_usb,
    input wire logic flow_en,
    input wire logic stream_en,
    // Received bytes from link
    input wire hmf_pkg::hmf_byte_t rx_byte,
    // Transmit byte to link
    output hmf_pkg::hmf_byte_t tx_byte,
    output logic tx_binary,
    input wire logic tx_ready,
    // Complete command out
    output logic cmd_valid,
    output logic [8*CMD_LEN-1:0] cmd_text,
    output logic [7:0] cmd_len,
    output logic cmd_error,
    // Reply bytes in, without terminator
    input wire hmf_pkg::hmf_byte_t reply_byte,
    input wire logic reply_last,
    output logic reply_ready,
    // Queue status and samples
    input wire logic data_q_nonempty,
    input wire logic err_q_nonempty,
    input wire logic sample_valid,
    input wire logic [8*REC_LEN-1:0] sample_rec,
    output logic sample_drop,
    // Parsed parameter of the last command argument
    output hmf_pkg::hmf_param_t param,
    // Keyword compare: long and short forms against last argument
    input wire logic [8*CMD_LEN-1:0] kw_long,
    input wire logic [7:0] kw_long_len,
    input wire logic [7:0] kw_short_len,
    output logic kw_match,
    // Serial flow state
    output logic xoff_active
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] to_up(input logic [7:0] c);
        to_up = (c >= 8'h61 && c <= 8'h7a) ? c - 8'h20 : c;
    endfunction
    function automatic logic is_dig(input logic [7:0] c);
        is_dig = (c >= 8'h30 && c <= 8'h39);
    endfunction
    function automatic logic [4:0] hex_nib(input logic [7:0] c);
        logic [7:0] u;
        u = to_up(c);
        if (is_dig(u)) hex_nib = {1'b1, u[3:0] - 4'h0};
        else if (u >= 8'h41 && u <= 8'h46) hex_nib = {1'b1, u[3:0] + 4'h9};
        else hex_nib = 5'h00;
    endfunction
    function automatic logic [7:0] cmd_ch(input logic [8*CMD_LEN-1:0] t, input int i);
        cmd_ch = t[8*i +: 8];
    endfunction

    // ------------------------------------------------------------
    // Receive framing
    // ------------------------------------------------------------
    logic [8*CMD_LEN-1:0] buf_ff, nxt_buf;
    logic [7:0] len_ff, nxt_len;
    logic cr_ff, nxt_cr;
    logic bad_ff, nxt_bad;
    logic cmd_valid_ff, nxt_cmd_valid;
    logic [8*CMD_LEN-1:0] cmd_text_ff, nxt_cmd_text;
    logic [7:0] cmd_len_ff, nxt_cmd_len;
    logic cmd_err_ff, nxt_cmd_err;
    logic xoff_ff, nxt_xoff;

    always_comb begin
        nxt_buf = buf_ff;
        nxt_len = len_ff;
        nxt_cr = cr_ff;
        nxt_bad = bad_ff;
        nxt_cmd_valid = 1'b0;
        nxt_cmd_text = cmd_text_ff;
        nxt_cmd_len = cmd_len_ff;
        nxt_cmd_err = cmd_err_ff;
        nxt_xoff = xoff_ff;
        if (!flow_en || use_usb) begin
            nxt_xoff = 1'b0;
        end
        if (rx_byte.valid) begin
            if (!use_usb && flow_en && rx_byte.data == hmf_pkg::CH_XOFF) begin
                nxt_xoff = 1'b1;
            end else if (!use_usb && flow_en && rx_byte.data == hmf_pkg::CH_XON) begin
                nxt_xoff = 1'b0;
            end else if (cr_ff && rx_byte.data == hmf_pkg::CH_LF) begin
                nxt_cmd_valid = 1'b1;
                nxt_cmd_text = buf_ff;
                nxt_cmd_len = len_ff;
                nxt_cmd_err = bad_ff;
                nxt_buf = '0;
                nxt_len = 8'h00;
                nxt_cr = 1'b0;
                nxt_bad = 1'b0;
            end else if (rx_byte.data == hmf_pkg::CH_CR) begin
                nxt_cr = 1'b1;
            end else begin
                if (cr_ff) begin
                    nxt_bad = 1'b1; // Lone CR
                end
                if (rx_byte.data[7]) begin
                    nxt_bad = 1'b1;
                end
                nxt_cr = 1'b0;
                if (len_ff < 8'(CMD_LEN)) begin
                    nxt_buf[8*len_ff +: 8] = rx_byte.data;
                    nxt_len = len_ff + 8'h01;
                end else begin
                    nxt_bad = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            buf_ff <= '0;
            len_ff <= 8'h00;
            cr_ff <= 1'b0;
            bad_ff <= 1'b0;
            cmd_valid_ff <= 1'b0;
            cmd_text_ff <= '0;
            cmd_len_ff <= 8'h00;
            cmd_err_ff <= 1'b0;
            xoff_ff <= hmf_pkg::RST_XOFF;
        end else begin
            buf_ff <= nxt_buf;
            len_ff <= nxt_len;
            cr_ff <= nxt_cr;
            bad_ff <= nxt_bad;
            cmd_valid_ff <= nxt_cmd_valid;
            cmd_text_ff <= nxt_cmd_text;
            cmd_len_ff <= nxt_cmd_len;
            cmd_err_ff <= nxt_cmd_err;
            xoff_ff <= nxt_xoff;
        end
    end

    // ------------------------------------------------------------
    // Parameter parsing of text after last space or tab
    // ------------------------------------------------------------
    hmf_pkg::hmf_param_t param_ff, nxt_param;
    logic kw_ff, nxt_kw;

    always_comb begin
        int st;
        int p;
        int dig;
        int kl;
        logic [7:0] c;
        logic [4:0] nb;
        logic seen_pt, in_exp, exp_neg, mant_dig, exp_dig, dec_bad, hex_bad, prefix;
        logic [31:0] hv, mv;
        logic [7:0] ev, fv;
        st = 0;
        p = 0;
        dig = 0;
        kl = 0;
        c = 8'h00;
        nb = 5'h00;
        seen_pt = 1'b0;
        in_exp = 1'b0;
        exp_neg = 1'b0;
        mant_dig = 1'b0;
        exp_dig = 1'b0;
        dec_bad = 1'b0;
        hex_bad = 1'b0;
        prefix = 1'b0;
        hv = 32'h0;
        mv = 32'h0;
        ev = 8'h00;
        fv = 8'h00;
        for (int i = 0; i < CMD_LEN; i++) begin
            if (i < int'(cmd_len_ff) && (cmd_ch(cmd_text_ff, i) == hmf_pkg::CH_SP ||
                cmd_ch(cmd_text_ff, i) == hmf_pkg::CH_TAB)) begin
                st = i + 1;
            end
        end
        prefix = (int'(cmd_len_ff) >= st + 2) && cmd_ch(cmd_text_ff, st) == 8'h30 &&
            to_up(cmd_ch(cmd_text_ff, st + 1)) == 8'h58;
        for (int i = 0; i < CMD_LEN; i++) begin
            if (i >= st && i < int'(cmd_len_ff)) begin
                c = cmd_ch(cmd_text_ff, i);
                p = i - st;
                if (!(prefix && p < 2)) begin
                    nb = hex_nib(c);
                    if (nb[4]) hv = {hv[27:0], nb[3:0]};
                    else hex_bad = 1'b1;
                end
                if (is_dig(c)) begin
                    dig = int'(c[3:0]);
                    if (in_exp) begin
                        ev = 8'(ev * 8'd10 + 8'(dig));
                        exp_dig = 1'b1;
                    end else begin
                        mv = 32'(mv * 32'd10 + 32'(dig));
                        mant_dig = 1'b1;
                        if (seen_pt) fv = fv - 8'h01;
                    end
                end else if ((c == 8'h2b || c == 8'h2d) && (p == 0 ||
                    (in_exp && to_up(cmd_ch(cmd_text_ff, i - 1)) == 8'h45))) begin
                    if (in_exp) exp_neg = (c == 8'h2d);
                end else if (c == 8'h2e && !seen_pt && !in_exp) begin
                    seen_pt = 1'b1;
                end else if (to_up(c) == 8'h45 && !in_exp && mant_dig) begin
                    in_exp = 1'b1;
                end else begin
                    dec_bad = 1'b1;
                end
            end
        end
        nxt_param = '0;
        nxt_param.valid = cmd_valid_ff;
        nxt_param.len = 8'(int'(cmd_len_ff) - st);
        nxt_param.hex_ok = !hex_bad && (int'(cmd_len_ff) > st + (prefix ? 2 : 0));
        nxt_param.hex_val = hv;
        nxt_param.is_hex = prefix;
        nxt_param.dec_ok = !dec_bad && mant_dig && (!in_exp || exp_dig);
        nxt_param.dec_sci = in_exp;
        nxt_param.dec_mant = mv;
        nxt_param.dec_exp = 8'((exp_neg ? 8'h00 - ev : ev) + fv);
        nxt_param.str_ok = int'(cmd_len_ff) > st && cmd_ch(cmd_text_ff, st) != 8'h22;
        nxt_kw = 1'b0;
        kl = int'(cmd_len_ff) - st;
        if (kl == int'(kw_long_len) || kl == int'(kw_short_len)) begin
            nxt_kw = kl > 0;
            for (int i = 0; i < CMD_LEN; i++) begin
                if (i < kl && to_up(cmd_ch(cmd_text_ff, (st + i) % CMD_LEN)) != to_up(cmd_ch(kw_long, i))) begin
                    nxt_kw = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            param_ff <= '0;
            kw_ff <= 1'b0;
        end else begin
            param_ff <= nxt_param;
            kw_ff <= nxt_kw;
        end
    end

    // ------------------------------------------------------------
    // Transmit path
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        HMF_TX_IDLE = 6'b000001,
        HMF_TX_REPLY = 6'b000010,
        HMF_TX_CR = 6'b000100,
        HMF_TX_LF = 6'b001000,
        HMF_TX_SRQ = 6'b010000,
        HMF_TX_REC = 6'b100000
    } hmf_tx_t;
    hmf_tx_t st_ff, nxt_st;
    hmf_pkg::hmf_byte_t tx_ff, nxt_tx;
    logic bin_ff, nxt_bin;
    logic [hmf_pkg::MSG_CNT_W-1:0] cnt_ff, nxt_cnt;
    logic q_ff, nxt_q, srq_ff, nxt_srq, rr_ff, nxt_rr, drop_ff, nxt_drop;
    logic [8*REC_LEN-1:0] rec_ff, nxt_rec;
    logic [7:0] ri_ff, nxt_ri;
    logic can_send;

    always_comb begin
        nxt_st = st_ff;
        nxt_tx = tx_ff;
        nxt_bin = bin_ff;
        nxt_cnt = cnt_ff;
        nxt_q = data_q_nonempty || err_q_nonempty;
        nxt_srq = srq_ff;
        nxt_rr = 1'b0;
        nxt_drop = 1'b0;
        nxt_rec = rec_ff;
        nxt_ri = ri_ff;
        can_send = !tx_ff.valid || tx_ready;
        if (tx_ff.valid && tx_ready) begin
            nxt_tx.valid = 1'b0;
            nxt_bin = 1'b0;
        end
        if (sample_valid && !(use_usb && stream_en && st_ff == HMF_TX_IDLE)) begin
            nxt_drop = use_usb && stream_en;
        end
        unique case (st_ff)
            HMF_TX_IDLE: begin
                if (sample_valid && use_usb && stream_en) begin
                    nxt_rec = sample_rec;
                    nxt_ri = 8'h00;
                    nxt_st = HMF_TX_REC;
                end else if (reply_byte.valid) begin
                    nxt_cnt = '0;
                    nxt_st = HMF_TX_REPLY;
                end else if (srq_ff && can_send && !(xoff_ff && !use_usb)) begin
                    nxt_srq = 1'b0;
                    nxt_bin = 1'b0;
                    if (use_usb) begin
                        nxt_tx = '{valid: 1'b1, data: hmf_pkg::CH_ENQ};
                        nxt_st = HMF_TX_CR;
                    end else begin
                        nxt_tx = '{valid: 1'b1, data: hmf_pkg::CH_ENQ};
                        nxt_st = HMF_TX_SRQ;
                    end
                end
            end
            HMF_TX_REPLY: begin
                if (can_send && !xoff_ff && reply_byte.valid && !rr_ff) begin
                    nxt_bin = 1'b0;
                    nxt_tx = '{valid: 1'b1, data: {1'b0, reply_byte.data[6:0]}};
                    nxt_rr = 1'b1;
                    nxt_cnt = cnt_ff + 1'b1;
                    if (reply_last || 32'(cnt_ff) + 32'd1 >= 32'(hmf_pkg::MAX_MSG_LEN - 2)) begin
                        nxt_st = HMF_TX_CR;
                    end
                end
            end
            HMF_TX_CR: begin
                if (can_send && !xoff_ff) begin
                    nxt_tx = '{valid: 1'b1, data: hmf_pkg::CH_CR};
                    nxt_st = HMF_TX_LF;
                end
            end
            HMF_TX_LF: begin
                if (can_send && !xoff_ff) begin
                    nxt_tx = '{valid: 1'b1, data: hmf_pkg::CH_LF};
                    nxt_st = HMF_TX_IDLE;
                end
            end
            HMF_TX_SRQ: begin
                nxt_st = HMF_TX_IDLE;
            end
            HMF_TX_REC: begin
                if (can_send) begin
                    nxt_bin = 1'b1;
                    nxt_tx = '{valid: 1'b1, data: rec_ff[8*ri_ff +: 8]};
                    nxt_ri = ri_ff + 8'h01;
                    if (ri_ff == 8'(REC_LEN - 1)) nxt_st = HMF_TX_IDLE;
                end
            end
        endcase
        if (nxt_q && !q_ff) begin
            nxt_srq = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_ff <= HMF_TX_IDLE;
            tx_ff <= '0;
            bin_ff <= 1'b0;
            cnt_ff <= '0;
            q_ff <= 1'b0;
            srq_ff <= 1'b0;
            rr_ff <= 1'b0;
            drop_ff <= 1'b0;
            rec_ff <= '0;
            ri_ff <= 8'h00;
        end else begin
            st_ff <= nxt_st;
            tx_ff <= nxt_tx;
            bin_ff <= nxt_bin;
            cnt_ff <= nxt_cnt;
            q_ff <= nxt_q;
            srq_ff <= nxt_srq;
            rr_ff <= nxt_rr;
            drop_ff <= nxt_drop;
            rec_ff <= nxt_rec;
            ri_ff <= nxt_ri;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign tx_byte = tx_ff;
    assign tx_binary = bin_ff;
    assign cmd_valid = cmd_valid_ff;
    assign cmd_text = cmd_text_ff;
    assign cmd_len = cmd_len_ff;
    assign cmd_error = cmd_err_ff;
    assign reply_ready = rr_ff;
    assign sample_drop = drop_ff;
    assign param = param_ff;
    assign kw_match = kw_ff;
    assign xoff_active = xoff_ff;
endmodule
`default_nettype wire

// [hmf_front_end_asserts.sv]
// Port checks for the host message framing front end
`timescale 1ns/1ps
`default_nettype none
module hmf_front_end_asserts (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Watched ports
    input wire logic use_usb,
    input wire logic flow_en,
    input wire hmf_pkg::hmf_byte_t rx_byte,
    input wire hmf_pkg::hmf_byte_t tx_byte,
    input wire logic tx_binary,
    input wire logic tx_ready,
    input wire logic cmd_valid,
    input wire logic reply_ready,
    input wire hmf_pkg::hmf_param_t param,
    input wire logic xoff_active
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    chk_tx_hold: assert property (
        tx_byte.valid && !tx_ready |=> tx_byte.valid && $stable(tx_byte.data))
        else $error("tx byte changed before acceptance");
    chk_xoff_halt: assert property (
        xoff_active && (!tx_byte.valid || tx_ready) |=> !tx_byte.valid)
        else $error("byte started while paused");
    chk_cmd_cause: assert property (
        cmd_valid |-> $past(rx_byte.valid) && $past(rx_byte.data) == hmf_pkg::CH_LF)
        else $error("command without line feed");
    chk_cmd_pair: assert property (
        rx_byte.valid && rx_byte.data == hmf_pkg::CH_CR ##1 rx_byte.valid && rx_byte.data == hmf_pkg::CH_LF
        |=> cmd_valid)
        else $error("terminator pair gave no command");
    chk_param_next: assert property (
        cmd_valid |=> param.valid ##1 !param.valid)
        else $error("parse result not one cycle after command");
    chk_reply_ascii: assert property (
        reply_ready |-> tx_byte.valid && !tx_byte.data[7] && !tx_binary)
        else $error("reply byte not plain text");
    chk_bin_usb: assert property (
        tx_binary |-> use_usb && tx_byte.valid)
        else $error("binary byte outside usb");
    chk_flow_clear: assert property (
        use_usb || !flow_en |=> !xoff_active)
        else $error("pause kept without flow control");
    chk_xoff_set: assert property (
        rx_byte.valid && rx_byte.data == hmf_pkg::CH_XOFF && flow_en && !use_usb |=> xoff_active)
        else $error("pause character ignored");
endmodule
bind hmf_front_end hmf_front_end_asserts u_hmf_front_end_asserts (.sys_clk(sys_clk), .srst(srst),
    .use_usb(use_usb), .flow_en(flow_en), .rx_byte(rx_byte), .tx_byte(tx_byte), .tx_binary(tx_binary),
    .tx_ready(tx_ready), .cmd_valid(cmd_valid), .reply_ready(reply_ready), .param(param),
    .xoff_active(xoff_active));
`default_nettype wire

// [hmf_host_model.sv]
// Host side of the link: sends bytes, accepts and logs transmitted bytes
`timescale 1ns/1ps
`default_nettype none
module hmf_host_model (
    // Clock
    input wire logic sys_clk,
    // Link
    output var hmf_pkg::hmf_byte_t rx_byte,
    input wire hmf_pkg::hmf_byte_t tx_byte,
    input wire logic tx_binary,
    output var logic tx_ready,
    // Stall control
    input wire logic slow
);
    logic [8:0] got[$];
    initial begin
        rx_byte = '0;
        tx_ready = 1'b0;
    end
    // ----
    // Accept bytes, stalling at random when slow
    // ----
    always @(posedge sys_clk) begin
        if (tx_byte.valid && tx_ready) begin
            got.push_back({tx_binary, tx_byte.data});
        end
        tx_ready <= #1 !slow || ($urandom % 2 == 0);
    end
    // Back-to-back bytes; caller starts just after an edge
    task automatic send(input logic [7:0] q[$]);
        foreach (q[i]) begin
            rx_byte = '{valid: 1'b1, data: q[i]};
            @(posedge sys_clk);
            #1;
        end
        rx_byte = '{valid: 1'b0, data: ~rx_byte.data};
    endtask
endmodule
`default_nettype wire

// [hmf_front_end_tb.sv]
// Self-checking testbench for the host message framing front end
`timescale 1ns/1ps
`default_nettype none
module hmf_front_end_tb;
    typedef logic [7:0] hmf_bq_t[$];
    localparam int CL = 32;
    localparam int RL = 4;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic use_usb = 1'b0;
    logic flow_en = 1'b1;
    logic stream_en = 1'b0;
    logic slow = 1'b0;
    logic reply_last = 1'b0;
    logic data_q_nonempty = 1'b0;
    logic err_q_nonempty = 1'b0;
    logic sample_valid = 1'b0;
    logic [8*RL-1:0] sample_rec = '0;
    logic [8*CL-1:0] kw_long = "REWOP";
    logic [7:0] kw_long_len = 8'h05;
    logic [7:0] kw_short_len = 8'h03;
    hmf_pkg::hmf_byte_t reply_byte = '0;
    hmf_pkg::hmf_byte_t rx_byte, tx_byte;
    hmf_pkg::hmf_param_t param, pr;
    logic tx_binary, tx_ready, cmd_valid, cmd_error, reply_ready, sample_drop, kw_match, xoff_active, km;
    logic [8*CL-1:0] cmd_text;
    logic [7:0] cmd_len;
    int n_errors = 0;
    int num_checks = 0;
    int ncmd = 0;
    int ndrop = 0;
    hmf_front_end #(.CMD_LEN(CL), .REC_LEN(RL)) u_hmf_front_end (.sys_clk, .srst, .use_usb, .flow_en,
        .stream_en, .rx_byte, .tx_byte, .tx_binary, .tx_ready, .cmd_valid, .cmd_text, .cmd_len, .cmd_error,
        .reply_byte, .reply_last, .reply_ready, .data_q_nonempty, .err_q_nonempty, .sample_valid, .sample_rec,
        .sample_drop, .param, .kw_long, .kw_long_len, .kw_short_len, .kw_match, .xoff_active);
    hmf_host_model u_hmf_host_model (.sys_clk, .rx_byte, .tx_byte, .tx_binary, .tx_ready, .slow);
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        ncmd += (cmd_valid === 1'b1);
        ndrop += (sample_drop === 1'b1);
        if (param.valid === 1'b1) begin
            pr = param;
            km = kw_match;
        end
    end
    // ----
    // Helpers
    // ----
    task automatic close_out();
        if (n_errors == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] a, input logic [31:0] e, input string m);
        num_checks++;
        if (a !== e) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, a, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    function automatic hmf_bq_t rnd(input int n);
        hmf_bq_t q;
        repeat (n) q.push_back(8'h41 + 8'($urandom % 26));
        return q;
    endfunction
    task automatic cmd(input string s, input logic er);
        hmf_bq_t q;
        int n0;
        n0 = ncmd;
        foreach (s[i]) q.push_back(s[i]);
        q.push_back(hmf_pkg::CH_CR);
        q.push_back(hmf_pkg::CH_LF);
        u_hmf_host_model.send(q);
        tick(3);
        chk(ncmd - n0, 1, s);
        chk(cmd_error, er, s);
        if (!er) chk(cmd_len, s.len(), s);
        if (!er) foreach (s[i]) chk(cmd_text[8*i+:8], s[i], s);
    endtask
    task automatic reply(input hmf_bq_t q);
        int w;
        foreach (q[i]) begin
            reply_byte = '{valid: 1'b1, data: q[i]};
            reply_last = (i == q.size() - 1);
            w = 0;
            do begin
                tick(1);
                w++;
            end while (reply_ready !== 1'b1 && w < 400);
        end
        reply_byte = '{valid: 1'b0, data: ~reply_byte.data};
        reply_last = 1'b0;
    endtask
    task automatic expect_tx(input hmf_bq_t e, input logic bin, input string m);
        for (int w = 0; w < 20000 && u_hmf_host_model.got.size() < e.size(); w++) tick(1);
        tick(10);
        chk(u_hmf_host_model.got.size(), e.size(), m);
        foreach (e[i]) chk(u_hmf_host_model.got[i], {bin, e[i]}, m);
        u_hmf_host_model.got.delete();
    endtask
    // ----
    // Scenarios
    // ----
    initial begin
        hmf_bq_t q, e;
        string h;
        string pre[3] = '{"", "0x", "0X"};
        string dec[6] = '{"31256", "31256.0", "3.1256E4", "31.256e3", "+3.1256E+4", "3.1x"};
        string kw[7] = '{"POW", "pow", "POWER", "PoWeR", "POWE", "PO", "POX"};
        logic [31:0] v;
        int n;
        void'($urandom(71041));
        repeat (3) @(posedge sys_clk);
        #1;
        srst = 1'b0;
        for (int i = 0; i < 8; i++) begin
            v = $urandom;
            h = (i % 2) ? $sformatf("%0h", v) : $sformatf("%h", v);
            if (i % 3 == 1) h = h.toupper();
            h = {pre[i % 3], h};
            cmd({"H ", h}, 1'b0);
            chk(pr.hex_ok, 1, h);
            chk(pr.hex_val, v, h);
            chk(pr.is_hex, i % 3 > 0, h);
        end
        cmd("H 0xG1", 1'b0);
        chk(pr.hex_ok, 0, "bad hex");
        foreach (dec[i]) begin
            cmd({"D ", dec[i]}, 1'b0);
            chk(pr.dec_ok, i < 5, dec[i]);
            if (i < 5) chk(pr.dec_exp, (i == 1) ? 8'hff : 8'h00, dec[i]);
        end
        foreach (kw[i]) begin
            cmd({"K ", kw[i]}, 1'b0);
            chk(km, i < 4, kw[i]);
        end
        cmd("S name", 1'b0);
        chk({pr.str_ok, pr.len}, 9'h104, "string");
        n = ncmd;
        u_hmf_host_model.send('{8'h41, hmf_pkg::CH_XOFF, 8'h42});
        tick(6);
        chk(ncmd - n, 0, "early command");
        u_hmf_host_model.send('{hmf_pkg::CH_XON, hmf_pkg::CH_CR, hmf_pkg::CH_LF});
        tick(3);
        chk(cmd_text[15:0], 16'h4241, "flow bytes kept");
        cmd({35{"Z"}}, 1'b1);
        u_hmf_host_model.send('{8'h41, 8'h80, hmf_pkg::CH_CR, hmf_pkg::CH_LF});
        tick(3);
        chk(cmd_error, 1, "non-ascii");
        cmd("OK", 1'b0);
        slow = 1'b1;
        reply('{8'hc1});
        expect_tx('{8'h41, hmf_pkg::CH_CR, hmf_pkg::CH_LF}, 1'b0, "ascii reply");
        for (int m = 0; m < 2; m++) begin
            use_usb = m[0];
            e = '{hmf_pkg::CH_ENQ};
            if (m == 1) e = '{hmf_pkg::CH_ENQ, hmf_pkg::CH_CR, hmf_pkg::CH_LF};
            q = rnd(1 + $urandom % 6);
            fork
                reply(q);
                begin
                    tick(2);
                    data_q_nonempty = 1'b1;
                end
            join
            q = {q, hmf_pkg::CH_CR, hmf_pkg::CH_LF, e};
            expect_tx(q, 1'b0, "reply then request");
            data_q_nonempty = 1'b0;
            tick(2);
            err_q_nonempty = 1'b1;
            expect_tx(e, 1'b0, "request");
            err_q_nonempty = 1'b0;
        end
        use_usb = 1'b0;
        slow = 1'b0;
        flow_en = 1'b0;
        u_hmf_host_model.send('{hmf_pkg::CH_XOFF});
        tick(2);
        chk(xoff_active, 0, "flow off");
        flow_en = 1'b1;
        q = rnd(8);
        fork
            reply(q);
            begin
                tick(6);
                u_hmf_host_model.send('{hmf_pkg::CH_XOFF});
                tick(3);
                n = u_hmf_host_model.got.size();
                tick(30);
                chk(u_hmf_host_model.got.size(), n, "sent while paused");
                chk(xoff_active, 1, "pause");
                u_hmf_host_model.send('{hmf_pkg::CH_XON});
            end
        join
        q = {q, hmf_pkg::CH_CR, hmf_pkg::CH_LF};
        expect_tx(q, 1'b0, "resumed");
        use_usb = 1'b1;
        for (int i = 0; i < 3; i++) begin
            n = ndrop;
            stream_en = (i > 0);
            sample_rec = $urandom;
            sample_valid = 1'b1;
            tick(1);
            sample_valid = (i == 2);
            tick(1);
            sample_valid = 1'b0;
            e = {};
            if (i > 0) for (int j = 0; j < RL; j++) e.push_back(sample_rec[8*j+:8]);
            expect_tx(e, 1'b1, "stream");
            chk(ndrop - n, i == 2, "drop");
        end
        use_usb = 1'b0;
        q = rnd(4100);
        reply(q);
        e = {q[0:4093], hmf_pkg::CH_CR, hmf_pkg::CH_LF, q[4094:4099], hmf_pkg::CH_CR, hmf_pkg::CH_LF};
        expect_tx(e, 1'b0, "long reply");
        close_out();
    end
    initial begin
        #400000;
        n_errors++;
        close_out();
    end
endmodule
`default_nettype wire
